// ===== osu_pkg.sv
// constants, fields and types of the oscillator supervisor
`default_nettype none
package osu_pkg;
   // register byte offsets
   localparam logic [7:0] CFG_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] MASK_OFF = 8'h08;
   localparam logic [7:0] STATE_OFF = 8'h0c;
   // field positions
   localparam int CFG_DISABLE_BIT = 0;
   localparam int CFG_PRESCALE_BIT = 1;
   localparam int STAT_MISS_BIT = 0;
   localparam int CFG_W = 2;
   localparam int STATE_W = 3;
   // reset values
   localparam logic [1:0] CFG_RESET = 2'h0;
   localparam logic STAT_RESET = 1'b0;
   localparam logic MASK_RESET = 1'b0;
   // ahb-lite codes
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;
   // supervising clock cycles without an oscillator edge before fallback
   localparam logic [7:0] MISS_LIMIT = 8'hc8;
   localparam logic [7:0] CNT_ONE = 8'h01;

   typedef struct packed {
      logic prescale;
      logic disable_sup;
   } osu_cfg_t;

   typedef struct packed {
      logic init_done;
      logic pll_run;
      logic fallback;
   } osu_state_t;

   typedef enum logic [3:0] {
      OSU_BUS_IDLE = 4'b0001,
      OSU_BUS_WR = 4'b0010,
      OSU_BUS_RDW = 4'b0100,
      OSU_BUS_RDD = 4'b1000
   } osu_bus_state_t;
endpackage : osu_pkg
`default_nettype wire

// ===== osu_osc_supervisor.sv
// oscillator supervisor with fallback clock control and ahb-lite registers
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`default_nettype none
module osu_osc_supervisor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic crystal_input,
   input wire logic external_access_n,
   input wire logic read_strobe_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic irq,
   output logic cpu_clk_src_pll,
   output logic fallback_clk_en,
   output logic pll_run
);

   osu_pkg::osu_bus_state_t bus_state_ff;
   osu_pkg::osu_bus_state_t nxt_bus_state;
   osu_pkg::osu_cfg_t cfg_ff;
   osu_pkg::osu_state_t state_view;
   logic [7:0] addr_ff;
   logic [31:0] hrdata_ff;
   logic [31:0] nxt_rdata;
   logic bus_accept;
   logic wr_en;
   logic init_done_ff;
   logic stat_miss_ff;
   logic mask_miss_ff;
   logic osc_s1_ff;
   logic osc_s2_ff;
   logic osc_s3_ff;
   logic osc_edge;
   logic [7:0] miss_cnt_ff;
   logic armed;
   logic miss_event;
   logic fallback_ff;
   logic fb_en_ff;
   logic pll_run_ff;

   // ---------------- ahb-lite slave ----------------
   assign bus_accept = hsel && htrans[1] && hready && (hsize == osu_pkg::HSIZE_WORD);
   assign wr_en = (bus_state_ff == osu_pkg::OSU_BUS_WR);

   always_comb begin
      case (bus_state_ff)
         osu_pkg::OSU_BUS_RDW: begin
            nxt_bus_state = osu_pkg::OSU_BUS_RDD;
         end
         osu_pkg::OSU_BUS_IDLE, osu_pkg::OSU_BUS_WR, osu_pkg::OSU_BUS_RDD: begin
            if (bus_accept) begin
               nxt_bus_state = hwrite ? osu_pkg::OSU_BUS_WR : osu_pkg::OSU_BUS_RDW;
            end else begin
               nxt_bus_state = osu_pkg::OSU_BUS_IDLE;
            end
         end
         default: begin
            nxt_bus_state = osu_pkg::OSU_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state_ff <= osu_pkg::OSU_BUS_IDLE;
      end else begin
         bus_state_ff <= nxt_bus_state;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_ff <= 8'h00;
      end else if (bus_accept) begin
         addr_ff <= haddr[7:0];
      end
   end

   // one wait state on reads so that a write just before is visible
   assign hreadyout = (bus_state_ff != osu_pkg::OSU_BUS_RDW);
   assign hresp = osu_pkg::HRESP_OKAY;
   assign hrdata = hrdata_ff;

   assign state_view = '{init_done: init_done_ff, pll_run: pll_run_ff, fallback: fallback_ff};

   always_comb begin
      case (addr_ff)
         osu_pkg::CFG_OFF: nxt_rdata = {30'h0, cfg_ff};
         osu_pkg::STATUS_OFF: nxt_rdata = {31'h0, stat_miss_ff};
         osu_pkg::MASK_OFF: nxt_rdata = {31'h0, mask_miss_ff};
         osu_pkg::STATE_OFF: nxt_rdata = {29'h0, state_view};
         default: nxt_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_ff <= 32'h0;
      end else if (bus_state_ff == osu_pkg::OSU_BUS_RDW) begin
         hrdata_ff <= nxt_rdata;
      end
   end

   // ---------------- configuration ----------------
   // strap capture on the first edge after reset release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         init_done_ff <= 1'b0;
      end else begin
         init_done_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= osu_pkg::osu_cfg_t'(osu_pkg::CFG_RESET);
      end else if (!init_done_ff) begin
         if (external_access_n) begin
            cfg_ff.disable_sup <= 1'b0;
         end else begin
            cfg_ff.disable_sup <= ~read_strobe_n;
         end
      end else if (wr_en && (addr_ff == osu_pkg::CFG_OFF)) begin
         cfg_ff <= osu_pkg::osu_cfg_t'(hwdata[osu_pkg::CFG_W-1:0]);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_miss_ff <= osu_pkg::MASK_RESET;
      end else if (wr_en && (addr_ff == osu_pkg::MASK_OFF)) begin
         mask_miss_ff <= hwdata[osu_pkg::STAT_MISS_BIT];
      end
   end

   // ---------------- oscillator watch ----------------
   // two-stage synchroniser, third stage only for edge detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_s1_ff <= 1'b0;
         osc_s2_ff <= 1'b0;
         osc_s3_ff <= 1'b0;
      end else begin
         osc_s1_ff <= crystal_input;
         osc_s2_ff <= osc_s1_ff;
         osc_s3_ff <= osc_s2_ff;
      end
   end

   assign osc_edge = osc_s2_ff ^ osc_s3_ff;
   assign armed = init_done_ff && !cfg_ff.disable_sup && !fallback_ff;
   // an edge that lands on the limit still counts as a live oscillator
   assign miss_event = armed && !osc_edge && (miss_cnt_ff == osu_pkg::MISS_LIMIT);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         miss_cnt_ff <= 8'h00;
      end else if (!armed || osc_edge) begin
         miss_cnt_ff <= 8'h00;
      end else if (miss_cnt_ff != osu_pkg::MISS_LIMIT) begin
         miss_cnt_ff <= miss_cnt_ff + osu_pkg::CNT_ONE;
      end
   end

   // only the hardware reset returns the cpu to the oscillator
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fallback_ff <= 1'b0;
      end else if (miss_event) begin
         fallback_ff <= 1'b1;
      end
   end

   // set wins over a simultaneous write-one-to-clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_miss_ff <= osu_pkg::STAT_RESET;
      end else if (miss_event) begin
         stat_miss_ff <= 1'b1;
      end else if (wr_en && (addr_ff == osu_pkg::STATUS_OFF) &&
                   hwdata[osu_pkg::STAT_MISS_BIT]) begin
         stat_miss_ff <= 1'b0;
      end
   end

   assign irq = stat_miss_ff && mask_miss_ff;

   // ---------------- clock steering ----------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fb_en_ff <= 1'b0;
      end else if (!fallback_ff) begin
         fb_en_ff <= 1'b0;
      end else if (cfg_ff.prescale) begin
         fb_en_ff <= ~fb_en_ff;
      end else begin
         fb_en_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_run_ff <= 1'b0;
      end else begin
         pll_run_ff <= !cfg_ff.disable_sup || fallback_ff;
      end
   end

   assign cpu_clk_src_pll = fallback_ff;
   assign fallback_clk_en = fb_en_ff;
   assign pll_run = pll_run_ff;

   // ---------------- checks ----------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_miss_to_fallback: assert property (
      (armed && !osc_edge && miss_cnt_ff == osu_pkg::MISS_LIMIT) |=>
         fallback_ff && cpu_clk_src_pll)
      else $error("missing oscillator did not select fallback clock");

   chk_fallback_sticky: assert property (
      fallback_ff |=> fallback_ff)
      else $error("fallback clock left without reset");

   chk_miss_irq_set: assert property (
      $rose(fallback_ff) |-> stat_miss_ff && (irq == mask_miss_ff))
      else $error("missing oscillator did not raise status");

   chk_disabled_no_event: assert property (
      cfg_ff.disable_sup |=> !$rose(stat_miss_ff) && !$rose(fallback_ff))
      else $error("event raised while supervision disabled");

   chk_direct_rate: assert property (
      (fallback_ff && !cfg_ff.prescale) [*2] |=> fb_en_ff)
      else $error("direct fallback clock not every cycle");

   chk_prescale_half: assert property (
      (fallback_ff && cfg_ff.prescale) [*3] |-> fb_en_ff != $past(fb_en_ff))
      else $error("prescaled fallback clock not halved");

   chk_pll_idle_off: assert property (
      (cfg_ff.disable_sup && !fallback_ff) [*2] |-> !pll_run && !cpu_clk_src_pll)
      else $error("pll running while supervision disabled");

   chk_strap_ext: assert property (
      ($rose(init_done_ff) && !$past(external_access_n)) |->
         cfg_ff.disable_sup == !$past(read_strobe_n))
      else $error("disable bit not taken from read strobe");

   chk_strap_int: assert property (
      ($rose(init_done_ff) && $past(external_access_n)) |-> !cfg_ff.disable_sup)
      else $error("disable bit not cleared after internal reset");

   chk_edge_restart: assert property (
      (osc_s2_ff != osc_s3_ff) |=> miss_cnt_ff == 8'h00)
      else $error("oscillator edge did not restart quiet count");

   chk_edge_keeps: assert property (
      (armed && osc_edge) |=> !fallback_ff)
      else $error("fallback taken while oscillator toggles");

   // bus timing, counter, status, interrupt and clock output checks
   chk_read_one_wait: assert property (
      (bus_accept && !hwrite) |=> !hreadyout ##1 hreadyout)
      else $error("read did not take exactly one wait state");

   chk_write_no_wait: assert property (
      (bus_accept && hwrite) |=> hreadyout)
      else $error("write data phase was stretched");

   chk_quiet_count_step: assert property (
      (armed && !osc_edge && miss_cnt_ff != osu_pkg::MISS_LIMIT) |=>
         miss_cnt_ff == $past(miss_cnt_ff) + osu_pkg::CNT_ONE)
      else $error("quiet count did not advance");

   chk_miss_at_limit: assert property (
      $rose(fallback_ff) |-> $past(miss_cnt_ff) == osu_pkg::MISS_LIMIT)
      else $error("fallback taken before the quiet limit");

   chk_disabled_count_zero: assert property (
      cfg_ff.disable_sup |=> miss_cnt_ff == 8'h00)
      else $error("quiet count ran while supervision disabled");

   chk_event_when_armed: assert property (
      $rose(stat_miss_ff) |-> $past(armed))
      else $error("status set while supervision not armed");

   chk_stat_sticky: assert property (
      (stat_miss_ff && !(wr_en && addr_ff == osu_pkg::STATUS_OFF &&
         hwdata[osu_pkg::STAT_MISS_BIT])) |=> stat_miss_ff)
      else $error("status bit lost without a clear");

   chk_clear_drops_irq: assert property (
      (wr_en && addr_ff == osu_pkg::STATUS_OFF && hwdata[osu_pkg::STAT_MISS_BIT] &&
         !miss_event) |=> !stat_miss_ff && !irq)
      else $error("write one did not clear status and interrupt");

   chk_pll_fallback_run: assert property (
      fallback_ff |=> pll_run)
      else $error("pll idle while cpu runs on fallback clock");

   chk_fbclk_idle_off: assert property (
      !fallback_ff |=> !fallback_clk_en)
      else $error("fallback clock enabled outside fallback");

   chk_pll_supervise_run: assert property (
      (init_done_ff && !cfg_ff.disable_sup) |=> pll_run)
      else $error("supervising pll idle while supervision enabled");

   cov_fallback_direct: cover property (
      $rose(fallback_ff) && !cfg_ff.prescale);
   cov_fallback_prescale: cover property (
      $rose(fallback_ff) && cfg_ff.prescale);
   cov_irq_raised: cover property (
      $rose(irq));
   cov_read_done: cover property (
      (bus_state_ff == osu_pkg::OSU_BUS_RDW) ##1 hreadyout);
   cov_disabled_idle: cover property (
      init_done_ff && cfg_ff.disable_sup && !pll_run);

endmodule : osu_osc_supervisor
`default_nettype wire

// ===== osu_osc_model.sv
// behavioural crystal oscillator that can be stopped
`default_nettype none
module osu_osc_model #(
   parameter int HALF_NS = 60
) (
   input wire logic run,
   output logic osc
);
   timeunit 1ns;
   timeprecision 1ps;
   // a dead crystal freezes at its last level
   initial begin
      osc = 1'b0;
      forever begin
         #(HALF_NS);
         if (run) begin
            osc = ~osc;
         end
      end
   end
endmodule : osu_osc_model
`default_nettype wire

// ===== oscillator_supervisor_tb.sv
// self-checking testbench of the oscillator supervisor
`default_nettype none
module oscillator_supervisor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, xtal, osc_run = 1'b1, ext_n = 1'b1, rs_n = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp, irq, src_pll, fb_en, pll_run;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic a, b;
   int fail_count = 0, n_tests = 0;
   assign hready = hreadyout;
   always #2 clk = ~clk;
   osu_osc_model u_osc (.run(osc_run), .osc(xtal));
   osu_osc_supervisor u_dut (.clk(clk), .rst_n(rst_n), .crystal_input(xtal),
      .external_access_n(ext_n), .read_strobe_n(rs_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
      .cpu_clk_src_pll(src_pll), .fallback_clk_en(fb_en), .pll_run(pll_run));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   // one ahb-lite single word transfer; ready sampled just before each edge
   task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
      logic ok;
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, ad};
      hwrite <= w;
      hsize <= osu_pkg::HSIZE_WORD;
      do begin
         @(negedge clk);
         ok = hreadyout;
         @(posedge clk);
      end while (ok !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(negedge clk);
         ok = hreadyout;
         rd = hrdata;
         @(posedge clk);
      end while (ok !== 1'b1);
   endtask : xfer

   task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
      xfer(1'b0, ad, 32'h0);
      check(rd, exp);
   endtask : rd_chk

   task automatic do_reset(input logic e, input logic r);
      @(posedge clk);
      rst_n <= 1'b0;
      ext_n <= e;
      rs_n <= r;
      osc_run <= 1'b1;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : do_reset

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : wait_cyc

   initial begin
      #100us;
      fail_count++;
      final_report();
   end

   initial begin
      do_reset(1'b1, 1'b0);
      rd_chk(osu_pkg::CFG_OFF, 32'h0);
      rd_chk(osu_pkg::STATE_OFF, 32'h6);
      rd_chk(8'h10, 32'h0);
      wait_cyc(400);
      check(src_pll, 1'b0);
      xfer(1'b1, osu_pkg::MASK_OFF, 32'h1);
      osc_run <= 1'b0;
      wait_cyc(260);
      check({src_pll, irq, hresp}, 3'b110);
      rd_chk(osu_pkg::STATUS_OFF, 32'h1);
      rd_chk(osu_pkg::STATE_OFF, 32'h7);
      repeat (3) begin
         @(negedge clk);
         check(fb_en, 1'b1);
      end
      xfer(1'b1, osu_pkg::CFG_OFF, 32'h2);
      wait_cyc(2);
      a = fb_en;
      @(negedge clk);
      b = fb_en;
      check(a ^ b, 1'b1);
      xfer(1'b1, osu_pkg::STATUS_OFF, 32'h1);
      wait_cyc(1);
      check(irq, 1'b0);
      xfer(1'b1, osu_pkg::CFG_OFF, 32'h0);
      osc_run <= 1'b1;
      wait_cyc(300);
      check(src_pll, 1'b1);
      // external hardware pulls the read strobe low to disable
      do_reset(1'b0, 1'b0);
      rd_chk(osu_pkg::CFG_OFF, 32'h1);
      check(pll_run, 1'b0);
      xfer(1'b1, osu_pkg::MASK_OFF, 32'h1);
      osc_run <= 1'b0;
      wait_cyc(300);
      check({irq, src_pll, pll_run}, 3'b000);
      rd_chk(osu_pkg::STATUS_OFF, 32'h0);
      do_reset(1'b0, 1'b1);
      rd_chk(osu_pkg::CFG_OFF, 32'h0);
      final_report();
   end
endmodule : oscillator_supervisor_tb
`default_nettype wire
